// *** design/ets_pkg.sv ***
// shared constants and types of the embedded trace sampler
package ets_pkg;
	localparam int DATA_W = 16;
	localparam int GROUPS = 8;
	localparam int GSEL_W = 4;
	localparam int XSRC = 4;
	localparam int DEPTH = 128;
	localparam int AW = 7;
	localparam int GAP_W = 6;
	localparam int WORD_W = DATA_W + GAP_W;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0010;
	localparam logic [GAP_W-1:0] FORCE_GAP = 6'h3F;
	localparam logic [7:0] DEPTH_CNT = 8'(DEPTH);
	localparam logic [7:0] POST_EARLY = 8'(DEPTH * 9 / 10);
	localparam logic [7:0] POST_MIDDLE = 8'(DEPTH / 2);
	localparam logic [7:0] POST_LATE = 8'(DEPTH - DEPTH * 9 / 10);
	// counter modes
	localparam logic [1:0] CM_EVENTS = 2'h0;
	localparam logic [1:0] CM_CYCLES = 2'h1;
	localparam logic [1:0] CM_PULSE = 2'h2;
	localparam logic [1:0] CM_WATCHDOG = 2'h3;
	// cross-trigger modes
	localparam logic [1:0] XM_DISABLED = 2'h0;
	localparam logic [1:0] XM_ANY = 2'h1;
	localparam logic [1:0] XM_AFTER = 2'h2;
	localparam logic [1:0] XM_ALL = 2'h3;
	// trigger positions
	localparam logic [1:0] TP_EARLY = 2'h0;
	localparam logic [1:0] TP_MIDDLE = 2'h1;
	localparam logic [1:0] TP_LATE = 2'h2;
	// sample modes
	localparam logic [1:0] SM_NORMAL = 2'h0;
	localparam logic [1:0] SM_QFILL = 2'h1;
	localparam logic [1:0] SM_QINTR = 2'h2;
	localparam logic [1:0] SM_ARMED = 2'h3;
	// offboard card type codes and stack codes
	localparam logic [2:0] CARD_OLDER = 3'h6;
	localparam logic [2:0] CARD_NEWER = 3'h7;
	localparam logic [1:0] STACK_1 = 2'h0;
	localparam logic [1:0] STACK_2 = 2'h1;
	localparam logic [1:0] STACK_4 = 2'h2;
	// self-test length and readback wait (addr reg, memory, two syncs)
	localparam logic [4:0] ST_LEN = 5'h10;
	localparam logic [2:0] ST_WAIT = 3'h4;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_ARMED = 6'h02,
		S_POST = 6'h04,
		S_DONE = 6'h08,
		S_STW = 6'h10,
		S_STR = 6'h20
	} ets_state_t;
	typedef struct packed {
		ets_state_t st;
		logic [2:0] grp;
		logic [1:0] pos;
		logic [1:0] smode;
		logic [CNT_W-1:0] preset;
		logic [CNT_W-1:0] cnt;
		logic run;
		logic after_ok;
		logic [XSRC:0] seen;
		logic [AW-1:0] wptr;
		logic [7:0] fill;
		logic [7:0] post;
		logic [AW-1:0] taddr;
		logic [DATA_W-1:0] last;
		logic last_v;
		logic [GAP_W-1:0] gap;
		logic ind_n;
		logic done;
		logic trig;
		logic ext_we;
		logic [AW-1:0] ext_addr;
		logic [WORD_W-1:0] ext_wd;
		logic [WORD_W-1:0] ext_s1;
		logic [WORD_W-1:0] ext_s2;
		logic [4:0] st_idx;
		logic [2:0] st_wait;
		logic st_done;
		logic st_fail;
	} ets_regs_t;
endpackage

// *** design/ets_sampler.sv ***
// trace sampler with trigger control, compression and trace buffer
//
// Contract
// - preset trigger counter, modes events/cycles/pulse/watchdog, preloadable
// - stop on n+1th event, n cycles after, n quiet, n held
// - cross-trigger modes disabled/any/after/all, after uses one source unit
// - ignore others; any source or own; all in any order; own after source
// - one of eight signal groups, numbered 1 to 8, captured per run
// - notification enabled: indicator output driven low on trigger
// - buffer in on-chip memory by default, optionally offboard RAM
// - compression skips unchanged samples, forces a store after 64
// - real-time debug units lack compression, qualified, armed, offboard RAM
// - offboard store uses 1, 2 or 4 stacked cards, on regular units only
// - card type code 6 for older family, 7 for newer
// - offboard clock external or internal, frequency given in MHz
// - buffer depth fixed at build, 128 samples by default
// - qualified sampling stores one sample per trigger then waits
// - qualified fill stops when full, qualified interrupt wraps until stop
// - always armed: new snapshot each trigger, keep latest, until stopped
// - early position: about 10 percent pre, 90 percent post
// - middle position is reset default, 50 percent each side
// - late position: about 90 percent pre, 10 percent post
// - self-test writes patterns offboard, reads back, flags mismatches
// - compression mask excludes chosen bits from change detection
`timescale 1ns/1ps
module ets_sampler (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [ets_pkg::GROUPS*ets_pkg::DATA_W-1:0] grp_data_i,
	input wire logic [ets_pkg::GSEL_W-1:0] group_i,
	input wire logic trig_i,
	input wire logic [ets_pkg::XSRC-1:0] xtrig_i,
	input wire logic [1:0] cross_mode_i,
	input wire logic [1:0] after_src_i,
	input wire logic counter_en_i,
	input wire logic [1:0] cnt_mode_i,
	input wire logic cnt_load_i,
	input wire logic [ets_pkg::CNT_W-1:0] cnt_val_i,
	input wire logic [1:0] trig_pos_i,
	input wire logic [1:0] sample_mode_i,
	input wire logic compress_i,
	input wire logic [ets_pkg::DATA_W-1:0] mask_i,
	input wire logic notify_en_i,
	input wire logic rtd_unit_i,
	input wire logic offboard_sel_i,
	input wire logic [1:0] stack_i,
	input wire logic card_newer_i,
	input wire logic clk_internal_i,
	input wire logic [7:0] clk_mhz_i,
	input wire logic arm_i,
	input wire logic stop_i,
	input wire logic rd_done_i,
	input wire logic selftest_i,
	input wire logic [ets_pkg::AW-1:0] rd_addr_i,
	input wire logic [ets_pkg::WORD_W-1:0] ext_rdata_i,
	output logic [ets_pkg::WORD_W-1:0] rd_data_o,
	output logic trigger_indicator_n_o,
	output logic trig_o,
	output logic done_o,
	output logic busy_o,
	output logic [ets_pkg::AW-1:0] trig_addr_o,
	output logic [ets_pkg::AW-1:0] wptr_o,
	output logic full_o,
	output logic ext_we_o,
	output logic [ets_pkg::AW-1:0] ext_addr_o,
	output logic [ets_pkg::WORD_W-1:0] ext_wdata_o,
	output logic [3:0] ext_cs_o,
	output logic [2:0] ext_card_type_o,
	output logic ext_clk_int_o,
	output logic [7:0] ext_clk_mhz_o,
	output logic st_done_o,
	output logic st_fail_o
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// group number 1..8 to mux index; out of range falls back to 1
	function automatic logic [2:0] grp_index(input logic [3:0] g);
		grp_index = (g >= 4'h1 && g <= 4'h8) ? 3'(g - 4'h1) : 3'h0;
	endfunction

	// self-test pattern, address folded in so stuck lines show
	function automatic logic [ets_pkg::WORD_W-1:0] st_pat(input logic [4:0] i);
		st_pat = {i[0], ~i[4:0], i[4:0], ~i[4:0], i[4:0], 1'b1};
	endfunction

	ets_pkg::ets_regs_t st_r;
	ets_pkg::ets_regs_t st_nxt;
	logic [ets_pkg::WORD_W-1:0] buf_mem [ets_pkg::DEPTH];
	logic [ets_pkg::WORD_W-1:0] rd_data_r;
	logic busy_r;
	logic full_r;
	logic [ets_pkg::DATA_W-1:0] sample;
	logic raw;
	logic fire;
	logic wr;
	logic changed;
	logic comp_on;
	logic qual;
	logic offb;
	logic [ets_pkg::WORD_W-1:0] word;

	// features that only regular units have
	assign comp_on = compress_i & ~rtd_unit_i;
	assign offb = offboard_sel_i & ~rtd_unit_i;
	assign qual = (st_r.smode == ets_pkg::SM_QFILL)
		| (st_r.smode == ets_pkg::SM_QINTR);
	assign sample = grp_data_i[st_r.grp*ets_pkg::DATA_W +: ets_pkg::DATA_W];
	// masked bits never count as a change
	assign changed = (((sample ^ st_r.last) & ~mask_i) != '0);
	assign word = {st_r.gap, sample};

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		raw = 1'b0;
		fire = 1'b0;
		wr = 1'b0;
		st_nxt.ext_we = 1'b0;
		st_nxt.trig = 1'b0;
		st_nxt.st_done = st_r.st_done;
		st_nxt.ext_s1 = ext_rdata_i;
		st_nxt.ext_s2 = st_r.ext_s1;
		// preload of the trigger counter
		if (cnt_load_i)
		begin
			st_nxt.preset = cnt_val_i;
			st_nxt.cnt = cnt_val_i;
		end
		// cross-trigger combination of own and source triggers
		case (cross_mode_i)
			ets_pkg::XM_ANY: raw = trig_i | (|xtrig_i);
			ets_pkg::XM_AFTER:
			begin
				// own trigger counts once the source has fired
				raw = trig_i & (st_r.after_ok | xtrig_i[after_src_i]);
				if (xtrig_i[after_src_i])
					st_nxt.after_ok = 1'b1;
				if (raw)
					st_nxt.after_ok = 1'b0;
			end
			ets_pkg::XM_ALL:
			begin
				st_nxt.seen = st_r.seen | {trig_i, xtrig_i};
				raw = &st_nxt.seen;
				if (raw)
					st_nxt.seen = '0;
			end
			default: raw = trig_i;
		endcase
		// counter qualification, only while a run listens
		if (!(st_r.st inside {ets_pkg::S_ARMED}))
			fire = 1'b0;
		else if (!counter_en_i)
			fire = raw;
		else
		begin
			case (cnt_mode_i)
				ets_pkg::CM_CYCLES:
				begin
					if (st_r.run || raw)
					begin
						st_nxt.run = 1'b1;
						if (st_r.cnt == '0)
							fire = 1'b1;
						else
							st_nxt.cnt = st_r.cnt - 1'b1;
					end
				end
				ets_pkg::CM_PULSE:
				begin
					if (!raw)
						st_nxt.cnt = st_r.preset;
					else if (st_r.cnt <= 16'h0001)
						fire = 1'b1;
					else
						st_nxt.cnt = st_r.cnt - 1'b1;
				end
				ets_pkg::CM_WATCHDOG:
				begin
					if (raw)
						st_nxt.cnt = st_r.preset;
					else if (st_r.cnt <= 16'h0001)
						fire = 1'b1;
					else
						st_nxt.cnt = st_r.cnt - 1'b1;
				end
				default:
				begin
					if (raw && st_r.cnt == '0)
						fire = 1'b1;
					else if (raw)
						st_nxt.cnt = st_r.cnt - 1'b1;
				end
			endcase
			if (fire)
			begin
				st_nxt.cnt = st_r.preset;
				st_nxt.run = 1'b0;
			end
		end
		// store decision: qualified stores only on the trigger
		if (st_r.st inside {ets_pkg::S_ARMED, ets_pkg::S_POST})
		begin
			if (qual)
				wr = fire;
			else if (comp_on && st_r.last_v)
				wr = changed | (st_r.gap == ets_pkg::FORCE_GAP);
			else
				wr = 1'b1;
		end
		if (st_r.st inside {ets_pkg::S_ARMED, ets_pkg::S_POST})
		begin
			st_nxt.gap = wr ? '0 : st_r.gap + 1'b1;
			if (wr)
			begin
				st_nxt.last = sample;
				st_nxt.last_v = 1'b1;
				st_nxt.wptr = st_r.wptr + 1'b1;
				if (st_r.fill != ets_pkg::DEPTH_CNT)
					st_nxt.fill = st_r.fill + 1'b1;
				st_nxt.ext_we = offb;
				st_nxt.ext_addr = st_r.wptr;
				st_nxt.ext_wd = word;
			end
		end
		if (fire)
		begin
			st_nxt.trig = 1'b1;
			st_nxt.taddr = st_r.wptr;
			if (notify_en_i)
				st_nxt.ind_n = 1'b0;
		end
		// capture sequencing
		case (st_r.st)
			ets_pkg::S_IDLE:
			begin
				if (arm_i && !st_r.done)
				begin
					st_nxt.st = ets_pkg::S_ARMED;
					st_nxt.grp = grp_index(group_i);
					st_nxt.pos = trig_pos_i;
					st_nxt.smode = rtd_unit_i ? ets_pkg::SM_NORMAL
						: sample_mode_i;
					st_nxt.wptr = '0;
					st_nxt.fill = '0;
					st_nxt.gap = '0;
					st_nxt.last_v = 1'b0;
					st_nxt.cnt = st_r.preset;
					st_nxt.run = 1'b0;
					st_nxt.seen = '0;
					st_nxt.after_ok = 1'b0;
					st_nxt.ind_n = 1'b1;
				end
				else if (selftest_i && offb)
				begin
					st_nxt.st = ets_pkg::S_STW;
					st_nxt.st_idx = '0;
					st_nxt.st_fail = 1'b0;
					st_nxt.st_done = 1'b0;
				end
			end
			ets_pkg::S_ARMED:
			begin
				if (stop_i)
					st_nxt.st = ets_pkg::S_DONE;
				else if (st_r.smode == ets_pkg::SM_QFILL)
				begin
					if (wr && st_r.fill == ets_pkg::DEPTH_CNT - 8'h01)
						st_nxt.st = ets_pkg::S_DONE;
				end
				else if (fire && !qual)
				begin
					st_nxt.st = ets_pkg::S_POST;
					case (st_r.pos)
						ets_pkg::TP_EARLY: st_nxt.post = ets_pkg::POST_EARLY;
						ets_pkg::TP_LATE: st_nxt.post = ets_pkg::POST_LATE;
						default: st_nxt.post = ets_pkg::POST_MIDDLE;
					endcase
				end
			end
			ets_pkg::S_POST:
			begin
				if (wr)
					st_nxt.post = st_r.post - 1'b1;
				if (stop_i)
					st_nxt.st = ets_pkg::S_DONE;
				else if (wr && st_r.post == 8'h01)
					// always armed rearms; taddr marks the latest snapshot
					st_nxt.st = (st_r.smode == ets_pkg::SM_ARMED)
						? ets_pkg::S_ARMED : ets_pkg::S_DONE;
			end
			ets_pkg::S_DONE:
			begin
				// hold complete until the host reports its readout
				st_nxt.done = 1'b1;
				st_nxt.ext_addr = rd_addr_i;
				if (st_r.done && rd_done_i)
				begin
					st_nxt.done = 1'b0;
					st_nxt.st = ets_pkg::S_IDLE;
				end
			end
			ets_pkg::S_STW:
			begin
				st_nxt.ext_we = 1'b1;
				st_nxt.ext_addr = 7'(st_r.st_idx);
				st_nxt.ext_wd = st_pat(st_r.st_idx);
				st_nxt.st_idx = st_r.st_idx + 1'b1;
				if (st_r.st_idx == ets_pkg::ST_LEN - 5'h01)
				begin
					st_nxt.st = ets_pkg::S_STR;
					st_nxt.st_idx = '0;
					st_nxt.st_wait = '0;
				end
			end
			ets_pkg::S_STR:
			begin
				st_nxt.ext_addr = 7'(st_r.st_idx);
				st_nxt.st_wait = st_r.st_wait + 1'b1;
				if (st_r.st_wait == ets_pkg::ST_WAIT)
				begin
					if (st_r.ext_s2 != st_pat(st_r.st_idx))
						st_nxt.st_fail = 1'b1;
					st_nxt.st_wait = '0;
					st_nxt.st_idx = st_r.st_idx + 1'b1;
					if (st_r.st_idx == ets_pkg::ST_LEN - 5'h01)
					begin
						st_nxt.st = ets_pkg::S_IDLE;
						st_nxt.st_done = 1'b1;
					end
				end
			end
			default: st_nxt.st = ets_pkg::S_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st_r <= '0;
			st_r.st <= ets_pkg::S_IDLE;
			st_r.pos <= ets_pkg::TP_MIDDLE;
			st_r.preset <= ets_pkg::CNT_RESET;
			st_r.cnt <= ets_pkg::CNT_RESET;
			st_r.ind_n <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// on-chip buffer; no reset so it maps onto block memory
	always_ff @(posedge clk_i)
	begin
		if (wr && !offb)
			buf_mem[st_r.wptr] <= word;
	end

	// host readout, offboard data comes through the synchroniser;
	// busy and full are fed from the next state so they stay flops
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rd_data_r <= '0;
			busy_r <= 1'b0;
			full_r <= 1'b0;
		end
		else
		begin
			rd_data_r <= offb ? st_r.ext_s2 : buf_mem[rd_addr_i];
			busy_r <= (st_nxt.st != ets_pkg::S_IDLE)
				&& (st_nxt.st != ets_pkg::S_DONE);
			full_r <= (st_nxt.fill == ets_pkg::DEPTH_CNT);
		end
	end

	// ------------------------------------------------------------
	// outputs and offboard card setup
	// ------------------------------------------------------------
	assign rd_data_o = rd_data_r;
	assign trigger_indicator_n_o = st_r.ind_n;
	assign trig_o = st_r.trig;
	assign done_o = st_r.done;
	assign busy_o = busy_r;
	assign trig_addr_o = st_r.taddr;
	assign wptr_o = st_r.wptr;
	assign full_o = full_r;
	assign ext_we_o = st_r.ext_we;
	assign ext_addr_o = st_r.ext_addr;
	assign ext_wdata_o = st_r.ext_wd;
	assign st_done_o = st_r.st_done;
	assign st_fail_o = st_r.st_fail;

	// card setup is static, so straps are simply registered
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ext_cs_o <= 4'h0;
			ext_card_type_o <= ets_pkg::CARD_OLDER;
			ext_clk_int_o <= 1'b0;
			ext_clk_mhz_o <= 8'h00;
		end
		else
		begin
			// same stack depth drives every location
			case (stack_i)
				ets_pkg::STACK_2: ext_cs_o <= offb ? 4'h3 : 4'h0;
				ets_pkg::STACK_4: ext_cs_o <= offb ? 4'hF : 4'h0;
				default: ext_cs_o <= offb ? 4'h1 : 4'h0;
			endcase
			ext_card_type_o <= card_newer_i ? ets_pkg::CARD_NEWER
				: ets_pkg::CARD_OLDER;
			ext_clk_int_o <= clk_internal_i;
			ext_clk_mhz_o <= clk_mhz_i;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_listen;
		st_r.st == ets_pkg::S_ARMED && !stop_i;
	endsequence
	sequence s_mid_fire;
		s_listen ##0 fire && !qual && st_r.pos == ets_pkg::TP_MIDDLE;
	endsequence

	property p_done_hold;
		done_o && !rd_done_i |=> done_o && !busy_o;
	endproperty
	a_done_hold: assert property (p_done_hold)
		else $error("complete status dropped before readout");
	property p_indicator;
		fire && notify_en_i |=> !trigger_indicator_n_o [*2];
	endproperty
	a_indicator: assert property (p_indicator)
		else $error("indicator not low after trigger");
	property p_events;
		counter_en_i && cnt_mode_i == ets_pkg::CM_EVENTS && fire
			|-> raw && st_r.cnt == '0;
	endproperty
	a_events: assert property (p_events)
		else $error("events mode fired early");
	property p_xdis;
		cross_mode_i == ets_pkg::XM_DISABLED && !counter_en_i && fire
			|-> trig_i;
	endproperty
	a_xdis: assert property (p_xdis)
		else $error("foreign trigger used while disabled");
	property p_force;
		s_listen ##0 comp_on && !qual && st_r.last_v
			&& st_r.gap == ets_pkg::FORCE_GAP |-> wr ##1 st_r.gap == '0;
	endproperty
	a_force: assert property (p_force)
		else $error("no forced store after 64 unchanged");
	property p_mask;
		s_listen ##0 comp_on && !qual && st_r.last_v && !changed
			&& st_r.gap != ets_pkg::FORCE_GAP |-> !wr;
	endproperty
	a_mask: assert property (p_mask)
		else $error("unchanged masked sample stored");
	property p_mid;
		s_mid_fire |=> st_r.post == ets_pkg::POST_MIDDLE
			&& st_r.st == ets_pkg::S_POST;
	endproperty
	a_mid: assert property (p_mid)
		else $error("middle position post count wrong");
	property p_qual;
		st_r.st == ets_pkg::S_ARMED && qual && wr |-> fire;
	endproperty
	a_qual: assert property (p_qual)
		else $error("qualified store without trigger");
	property p_qfill;
		s_listen ##0 st_r.smode == ets_pkg::SM_QFILL && wr
			&& st_r.fill == ets_pkg::DEPTH_CNT - 8'h01 |=> ##[1:2] done_o;
	endproperty
	a_qfill: assert property (p_qfill)
		else $error("qualified fill did not stop when full");
	property p_rtd;
		rtd_unit_i && $past(rtd_unit_i) && st_r.st != ets_pkg::S_STR
			&& st_r.st != ets_pkg::S_STW |=> !ext_we_o;
	endproperty
	a_rtd: assert property (p_rtd)
		else $error("real-time unit wrote offboard");
endmodule

// *** test/ets_ram_model.sv ***
// offboard trace store model sitting on the sampler's external ram port
`timescale 1ns/1ps
module ets_ram_model (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [ets_pkg::AW-1:0] addr_i,
	input wire logic [ets_pkg::WORD_W-1:0] wdata_i,
	input wire logic stuck_i,
	output logic [ets_pkg::WORD_W-1:0] rdata_o
);
	logic [ets_pkg::WORD_W-1:0] mem_r [0:ets_pkg::DEPTH-1];
	logic [ets_pkg::WORD_W-1:0] flip;

	// stuck_i inverts bit 0 so the bench can fake a broken data line
	assign flip = {{(ets_pkg::WORD_W-1){1'h0}}, stuck_i};

	// synchronous ram, read data one cycle after the address
	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem_r[addr_i] <= wdata_i;
		rdata_o <= mem_r[addr_i] ^ flip;
	end
endmodule

// *** test/tb.sv ***
// self-checking bench of the trace sampler against an offboard store model
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'h0;
	logic reset_n_i = 1'h0;
	logic [127:0] grp_data_i = '0;
	logic [15:0] cnt_val_i = '0, mask_i = '0;
	logic [7:0] clk_mhz_i = '0;
	logic [6:0] rd_addr_i = '0, wa, ta;
	logic [3:0] group_i = 4'h3, xtrig_i = '0;
	logic [1:0] cross_mode_i = '0, after_src_i = '0, cnt_mode_i = '0;
	logic [1:0] trig_pos_i = 2'h1, sample_mode_i = '0, stack_i = '0;
	logic trig_i = 1'h0, counter_en_i = 1'h0, cnt_load_i = 1'h0;
	logic compress_i = 1'h0, notify_en_i = 1'h1, rtd_unit_i = 1'h0;
	logic offboard_sel_i = 1'h0, card_newer_i = 1'h0, clk_internal_i = 1'h0;
	logic arm_i = 1'h0, stop_i = 1'h0, rd_done_i = 1'h0, selftest_i = 1'h0;
	logic stuck = 1'h0, quiet = 1'h0, rd_v = 1'h0, rd_v_d = 1'h0;
	logic [21:0] ext_rdata_i, rd_data_o, ext_wdata_o;
	logic [6:0] trig_addr_o, wptr_o, ext_addr_o;
	logic [3:0] ext_cs_o;
	logic [2:0] ext_card_type_o;
	logic [7:0] ext_clk_mhz_o;
	logic trigger_indicator_n_o, trig_o, done_o, busy_o, full_o, ext_we_o;
	logic ext_clk_int_o, st_done_o, st_fail_o;
	logic [31:0] seed = 32'h13A887A3;
	logic [15:0] exp_q[$];
	logic [15:0] tdat[5];
	int miscompares = 0, total_checks = 0, trig_cnt = 0, n;
	int posts[3];

	// 20 MHz sample clock
	always #25 clk_i = ~clk_i;

	ets_sampler uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.grp_data_i(grp_data_i), .group_i(group_i), .trig_i(trig_i),
		.xtrig_i(xtrig_i), .cross_mode_i(cross_mode_i),
		.after_src_i(after_src_i), .counter_en_i(counter_en_i),
		.cnt_mode_i(cnt_mode_i), .cnt_load_i(cnt_load_i),
		.cnt_val_i(cnt_val_i), .trig_pos_i(trig_pos_i),
		.sample_mode_i(sample_mode_i), .compress_i(compress_i),
		.mask_i(mask_i), .notify_en_i(notify_en_i), .rtd_unit_i(rtd_unit_i),
		.offboard_sel_i(offboard_sel_i), .stack_i(stack_i),
		.card_newer_i(card_newer_i), .clk_internal_i(clk_internal_i),
		.clk_mhz_i(clk_mhz_i), .arm_i(arm_i), .stop_i(stop_i),
		.rd_done_i(rd_done_i), .selftest_i(selftest_i),
		.rd_addr_i(rd_addr_i), .ext_rdata_i(ext_rdata_i),
		.rd_data_o(rd_data_o), .trigger_indicator_n_o(trigger_indicator_n_o),
		.trig_o(trig_o), .done_o(done_o), .busy_o(busy_o),
		.trig_addr_o(trig_addr_o), .wptr_o(wptr_o), .full_o(full_o),
		.ext_we_o(ext_we_o), .ext_addr_o(ext_addr_o),
		.ext_wdata_o(ext_wdata_o), .ext_cs_o(ext_cs_o),
		.ext_card_type_o(ext_card_type_o), .ext_clk_int_o(ext_clk_int_o),
		.ext_clk_mhz_o(ext_clk_mhz_o), .st_done_o(st_done_o),
		.st_fail_o(st_fail_o));

	ets_ram_model ram (.clk_i(clk_i), .we_i(ext_we_o), .addr_i(ext_addr_o),
		.wdata_i(ext_wdata_o), .stuck_i(stuck), .rdata_o(ext_rdata_i));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic sig(input int s);
		if (s == 0)
			return done_o;
		return st_done_o;
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	// quiet data toggles only bit 0 of every group, the masked bit
	task automatic step();
		@(negedge clk_i);
		seed = lfsr_next(seed);
		grp_data_i = quiet ? {8{15'h0, seed[0]}} : {4{seed}};
	endtask

	task automatic wait_hi(input int s, input int lim, output int k);
		k = 0;
		while (sig(s) !== 1'h1 && k < lim)
		begin
			step();
			k++;
		end
		if (k >= lim)
		begin
			chk("wait", 1, 0);
			tally_and_finish();
		end
	endtask

	task automatic arm();
		arm_i = 1'h1;
		step();
		arm_i = 1'h0;
	endtask

	// one cycle of trigger levels, then count trig_o pulses seen
	task automatic pulse(input logic [3:0] x, input logic t, input int e);
		int c0;
		c0 = trig_cnt;
		xtrig_i = x;
		trig_i = t;
		step();
		xtrig_i = 4'h0;
		trig_i = 1'h0;
		repeat (4) step();
		chk("trig_o", e, trig_cnt - c0);
	endtask

	task automatic rd_word(input logic [6:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		rd_addr_i = a;
		rd_v = 1'h1;
		step();
	endtask

	// a refused re-arm while complete, then the host readout handshake
	task automatic close_run();
		wait_hi(0, 400, n);
		rd_v = 1'h0;
		stop_i = 1'h0;
		arm();
		step();
		chk("busy", 0, busy_o);
		rd_done_i = 1'h1;
		step();
		rd_done_i = 1'h0;
		step();
		chk("done", 0, done_o);
	endtask

	// ------------------------------------------------------------
	// result watcher
	// ------------------------------------------------------------
	always @(posedge clk_i)
		rd_v_d <= rd_v;

	// read data lands one cycle after the address, compared here
	always @(negedge clk_i)
	begin
		if (trig_o === 1'h1)
			trig_cnt++;
		if (rd_v_d === 1'h1 && exp_q.size() > 0)
			chk("rd_data", exp_q.pop_front(), rd_data_o[15:0]);
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		posts = '{int'(ets_pkg::POST_EARLY), int'(ets_pkg::POST_MIDDLE),
			int'(ets_pkg::POST_LATE)};
		repeat (12) @(negedge clk_i);
		chk("indicator", 1, trigger_indicator_n_o);
		chk("card", 6, ext_card_type_o);
		reset_n_i = 1'h1;
		step();
		// trigger position split, group 3 sample at the trigger address
		for (int p = 0; p < 3; p++)
		begin
			trig_pos_i = 2'(p);
			arm();
			repeat (20) step();
			tdat[0] = grp_data_i[47:32];
			pulse(4'h0, 1'h1, 1);
			chk("indicator", 0, trigger_indicator_n_o);
			ta = trig_addr_o;
			wait_hi(0, 300, n);
			chk("post", 1, (n + 5 - posts[p]) inside {[0:6]});
			rd_word(ta, tdat[0]);
			close_run();
		end
		// events counter: fires on the third trigger with n = 2
		counter_en_i = 1'h1;
		cnt_mode_i = ets_pkg::CM_EVENTS;
		cnt_val_i = 16'h0002;
		cnt_load_i = 1'h1;
		step();
		cnt_load_i = 1'h0;
		arm();
		pulse(4'h0, 1'h1, 0);
		pulse(4'h0, 1'h1, 0);
		pulse(4'h0, 1'h1, 1);
		close_run();
		// cycles, pulse width and watchdog, each with n = 2
		for (int c = 1; c < 4; c++)
		begin
			cnt_mode_i = 2'(c);
			arm();
			trig_i = (c == 2);
			step();
			pulse(4'h0, c != 3, 1);
			stop_i = 1'h1;
			close_run();
		end
		counter_en_i = 1'h0;
		// cross triggering: disabled, any, after, all
		arm();
		pulse(4'h4, 1'h0, 0);
		cross_mode_i = ets_pkg::XM_ANY;
		pulse(4'h4, 1'h0, 1);
		stop_i = 1'h1;
		close_run();
		cross_mode_i = ets_pkg::XM_AFTER;
		after_src_i = 2'h1;
		arm();
		pulse(4'h0, 1'h1, 0);
		pulse(4'h2, 1'h0, 0);
		pulse(4'h0, 1'h1, 1);
		stop_i = 1'h1;
		close_run();
		cross_mode_i = ets_pkg::XM_ALL;
		arm();
		pulse(4'h5, 1'h0, 0);
		pulse(4'hA, 1'h0, 0);
		pulse(4'h0, 1'h1, 1);
		stop_i = 1'h1;
		close_run();
		cross_mode_i = ets_pkg::XM_DISABLED;
		// compression with bit 0 masked, then a real-time unit
		compress_i = 1'h1;
		mask_i = 16'h0001;
		quiet = 1'h1;
		for (int r = 0; r < 2; r++)
		begin
			rtd_unit_i = 1'(r);
			sample_mode_i = 2'(r);
			offboard_sel_i = 1'(r);
			arm();
			step();
			wa = wptr_o;
			repeat (100) step();
			if (r == 0)
				chk("skip", 1, 7'(wptr_o - wa) inside {[1:2]});
			else
				chk("rtd", 100, 7'(wptr_o - wa));
			chk("cs", 0, ext_cs_o);
			stop_i = 1'h1;
			close_run();
		end
		rtd_unit_i = 1'h0;
		offboard_sel_i = 1'h0;
		compress_i = 1'h0;
		quiet = 1'h0;
		// qualified fill and qualified interrupt: one sample per trigger
		for (int m = 1; m < 3; m++)
		begin
			sample_mode_i = 2'(m);
			arm();
			step();
			wa = wptr_o;
			for (int k = 0; k < 5; k++)
			begin
				tdat[k] = grp_data_i[47:32];
				pulse(4'h0, 1'h1, 1);
			end
			chk("qual", 5, 7'(wptr_o - wa));
			// fill mode ends by itself once a held trigger fills the buffer
			trig_i = (m == 1);
			stop_i = (m == 2);
			wait_hi(0, 300, n);
			trig_i = 1'h0;
			chk("full", m == 1, full_o);
			for (int k = 0; k < 5; k++)
				rd_word(7'(wa + 7'(k)), tdat[k]);
			close_run();
		end
		// always armed keeps the snapshot of the latest trigger
		sample_mode_i = ets_pkg::SM_ARMED;
		arm();
		repeat (10) step();
		pulse(4'h0, 1'h1, 1);
		repeat (80) step();
		tdat[0] = grp_data_i[47:32];
		pulse(4'h0, 1'h1, 1);
		ta = trig_addr_o;
		repeat (70) step();
		stop_i = 1'h1;
		wait_hi(0, 300, n);
		chk("trig_addr", ta, trig_addr_o);
		rd_word(ta, tdat[0]);
		close_run();
		// offboard store setup, card stacks and self-test
		offboard_sel_i = 1'h1;
		card_newer_i = 1'h1;
		clk_internal_i = 1'h1;
		clk_mhz_i = 8'h64;
		for (int s = 0; s < 3; s++)
		begin
			stack_i = 2'(s);
			repeat (2) step();
			chk("cs", (32'h1 << (1 << s)) - 1, ext_cs_o);
		end
		chk("card", 7, ext_card_type_o);
		chk("clk_int", 1, ext_clk_int_o);
		chk("clk_mhz", 32'h64, ext_clk_mhz_o);
		for (int f = 0; f < 2; f++)
		begin
			stuck = 1'(f);
			selftest_i = 1'h1;
			step();
			selftest_i = 1'h0;
			step();
			wait_hi(1, 400, n);
			chk("st_fail", f, st_fail_o);
		end
		tally_and_finish();
	end
endmodule
